// ### est_irq_src.sv
/*
 Peripheral request model: pulses one request line per command.
 Assumes go and sel change at the rising edge of core_clk.
*/
`timescale 1ns/100ps
module est_irq_src (
    // Clock
    input  wire logic        core_clk,
    // Command
    input  wire logic        go,
    input  wire logic [3:0]  sel,
    // Requests
    output logic      [15:0] irq_req = 16'h0000
);
    // One cycle only: a held level would pend again after service
    always @(posedge core_clk) begin
        irq_req <= go ? (16'h0001 << sel) : 16'h0000;
    end
endmodule : est_irq_src

// ### est_map.svh
/*
 Exception state tracker constants: exception numbers, vector offsets,
 fixed priorities and sizes. Assumes inclusion from the package only, compiled ahead of the design.
*/
`ifndef EST_MAP_SVH
`define EST_MAP_SVH
`define EST_NUM_IRQ        16
`define EST_NUM_EXC        32
`define EST_PRIO_W         8
`define EST_IDX_W          5
`define EST_EXC_RESET      5'h01
`define EST_EXC_NMI        5'h02
`define EST_EXC_HARD       5'h03
`define EST_EXC_BUS        5'h05
`define EST_EXC_USAGE      5'h06
`define EST_EXC_SUPV       5'h0b
`define EST_EXC_DEFER      5'h0e
`define EST_EXC_TICK       5'h0f
`define EST_EXC_IRQ0       5'h10
`define EST_VEC_RESET      32'h0000_0004
`define EST_VEC_STEP       32'h0000_0004
`define EST_PRIO_RESET     8'sh00
`define EST_RANK_RESET     10'sh3fd
`define EST_RANK_NMI       10'sh3fe
`define EST_RANK_HARD      10'sh3ff
`define EST_PRIO_RST_VAL   8'h00
`define EST_RANK_NONE      10'sh1ff
`endif

// ### est_pkg.sv
/*
 Types for the exception state tracker.
 Assumes est_map.svh is on the include path.
*/
`include "est_map.svh"
package est_pkg;
    typedef enum logic [1:0] {
        EST_INACTIVE   = 2'b00,
        EST_PENDING    = 2'b01,
        EST_ACTIVE     = 2'b10,
        EST_ACT_PEND   = 2'b11
    } est_state_t;

    typedef enum logic [1:0] {
        EST_CORE_RESET  = 2'b00,
        EST_CORE_FETCH  = 2'b01,
        EST_CORE_RUN    = 2'b10
    } est_core_t;

    // Fault and trap events from the pipeline, one cycle pulses
    typedef struct packed {
        logic undef_instr;
        logic illegal_unaligned;
        logic invalid_state;
        logic exc_return_err;
        logic unaligned_access;
        logic div_by_zero;
        logic bus_error;
        logic exc_proc_error;
        logic unhandled_fault;
        logic supervisor_call;
    } est_events_t;

    typedef struct packed {
        logic                      valid;
        logic [`EST_IDX_W-1:0]     num;
        logic [31:0]               vec_addr;
    } est_take_t;
endpackage : est_pkg

// ### est_tracker.sv
/*
 Exception state tracker: per-exception inactive/pending/active state,
 nesting, fixed and configurable priorities, and entry/return handshake.
 Assumes the pipeline reports events and handler entry/return on core_clk,
 and that peripheral request lines are synchronous to core_clk.
*/
// Functional notes
// - Idle sources sit inactive: neither pending nor active.
// - Peripheral or software requests pend the exception until serviced.
// - Handlers may nest; every preempted handler stays marked active.
// - A request to an already active source makes it active and pending.
// - Reset stops everything at once, mid-instruction included.
// - After reset, restart address comes from the reset vector entry.
// - After reset, run privileged in thread mode.
// - Non-maskable request from pin or software; always enabled, priority -2.
// - Nothing masks the non-maskable exception; only reset preempts it.
// - Hard fault has fixed priority -1, above all configurable ones.
// - Exception-processing errors and unhandled faults raise a hard fault.
// - Fetch or data bus errors raise a bus fault.
// - Undefined, illegal unaligned, bad state, bad return raise usage fault.
// - Unaligned and divide-by-zero raise usage fault only when enabled.
// - Supervisor call instruction raises the supervisor call exception.
// - Deferred service request exception is pended on request.
// - Timer reaching zero or software pends the system tick exception.
// - Lower priority value means more urgent.
// - Configurable priorities reset to zero.
// - Interrupt vectors start at first interrupt entry, 4 bytes apart.
`timescale 1ns/100ps
module est_tracker (
    // Clock and reset
    input  wire logic                               core_clk,
    input  wire logic                               rst_n,
    // Request sources
    input  wire logic [`EST_NUM_IRQ-1:0]            irq_req,
    input  wire logic [`EST_NUM_IRQ-1:0]            irq_enable,
    input  wire logic                               nmi_pin,
    input  wire logic                               nmi_sw_set,
    input  wire logic                               deferred_service_request_set,
    input  wire logic                               tick_zero,
    input  wire logic                               tick_sw_set,
    input  wire logic                               bus_fault_enable,
    input  wire logic                               usage_fault_enable,
    input  wire logic                               unaligned_trap_enable,
    input  wire logic                               div_zero_trap_enable,
    input  wire est_pkg::est_events_t               events,
    // Priorities, one byte per exception number
    input  wire logic [`EST_NUM_EXC*`EST_PRIO_W-1:0] prio_cfg,
    input  wire logic                               prio_cfg_we,
    // Pipeline handshake
    input  wire logic                               take_ready,
    input  wire logic                               handler_return,
    input  wire logic [`EST_IDX_W-1:0]              return_num,
    input  wire logic                               fetch_done,
    // Outputs
    output est_pkg::est_take_t                      take,
    output logic [2*`EST_NUM_EXC-1:0]               exc_state,
    output logic [31:0]                             restart_addr,
    output logic                                    restart_fetch,
    output logic                                    core_run,
    output logic                                    handler_mode,
    output logic                                    privileged
);
    logic [`EST_NUM_EXC-1:0]             set_req;
    logic [`EST_NUM_EXC-1:0]             en_mask;
    logic [`EST_NUM_EXC-1:0]             pend_q;
    logic [`EST_NUM_EXC-1:0]             pend_d;
    logic [`EST_NUM_EXC-1:0]             act_q;
    logic [`EST_NUM_EXC-1:0]             act_d;
    logic [`EST_NUM_EXC*`EST_PRIO_W-1:0] prio_q;
    logic [`EST_NUM_EXC*`EST_PRIO_W-1:0] prio_d;
    logic signed [9:0]                   rank [`EST_NUM_EXC];
    logic signed [9:0]                   best_rank;
    logic [`EST_IDX_W-1:0]               best_num;
    logic                                best_ok;
    logic signed [9:0]                   run_rank;
    logic                                take_fire;
    logic                                usage_hit;
    logic                                bus_hit;
    logic                                hard_hit;
    est_pkg::est_state_t                 st_cur;
    est_pkg::est_state_t                 st_nxt;
    logic                                ret_hit;
    logic                                take_hit;
    est_pkg::est_core_t                  core_q;
    est_pkg::est_core_t                  core_d;
    est_pkg::est_take_t                  take_q;
    est_pkg::est_take_t                  take_d;

    // Fault classification
    always_comb begin
        usage_hit = events.undef_instr | events.illegal_unaligned
                  | events.invalid_state | events.exc_return_err
                  | (events.unaligned_access & unaligned_trap_enable)
                  | (events.div_by_zero & div_zero_trap_enable);
        bus_hit   = events.bus_error;
        // A disabled fault escalates, so it is never silently dropped
        hard_hit  = events.exc_proc_error | events.unhandled_fault
                  | (usage_hit & ~usage_fault_enable)
                  | (bus_hit & ~bus_fault_enable);
    end

    // Request and enable vectors indexed by exception number
    always_comb begin
        set_req = '0;
        en_mask = '0;
        set_req[`EST_EXC_NMI]   = nmi_pin | nmi_sw_set;
        set_req[`EST_EXC_HARD]  = hard_hit;
        set_req[`EST_EXC_BUS]   = bus_hit & bus_fault_enable;
        set_req[`EST_EXC_USAGE] = usage_hit & usage_fault_enable;
        set_req[`EST_EXC_SUPV]  = events.supervisor_call;
        set_req[`EST_EXC_DEFER] = deferred_service_request_set;
        set_req[`EST_EXC_TICK]  = tick_zero | tick_sw_set;
        set_req[`EST_NUM_EXC-1:`EST_EXC_IRQ0] = irq_req;
        en_mask[`EST_EXC_NMI]   = 1'b1;
        en_mask[`EST_EXC_HARD]  = 1'b1;
        en_mask[`EST_EXC_BUS]   = 1'b1;
        en_mask[`EST_EXC_USAGE] = 1'b1;
        en_mask[`EST_EXC_SUPV]  = 1'b1;
        en_mask[`EST_EXC_DEFER] = 1'b1;
        en_mask[`EST_EXC_TICK]  = 1'b1;
        en_mask[`EST_NUM_EXC-1:`EST_EXC_IRQ0] = irq_enable;
    end

    // Priority rank per exception; fixed ones below any configurable
    genvar gi;
    generate
        for (gi = 0; gi < `EST_NUM_EXC; gi++) begin : g_rank
            always_comb begin
                if (gi == `EST_EXC_NMI) begin
                    rank[gi] = `EST_RANK_NMI;
                end else if (gi == `EST_EXC_HARD) begin
                    rank[gi] = `EST_RANK_HARD;
                end else begin
                    rank[gi] = 10'($unsigned(prio_q[gi*`EST_PRIO_W +: `EST_PRIO_W]));
                end
            end
        end
    endgenerate

    // Most urgent pending enabled exception, and running priority
    always_comb begin
        best_rank = `EST_RANK_NONE;
        best_num  = '0;
        best_ok   = 1'b0;
        run_rank  = `EST_RANK_NONE;
        for (int i = `EST_NUM_EXC - 1; i > 0; i--) begin
            if (pend_q[i] && en_mask[i] && rank[i] <= best_rank) begin
                best_rank = rank[i];
                best_num  = i[`EST_IDX_W-1:0];
                best_ok   = 1'b1;
            end
            if (act_q[i] && rank[i] <= run_rank) begin
                run_rank = rank[i];
            end
        end
    end

    // Strictly more urgent preempts; NMI thus yields only to reset
    assign take_fire = (core_q == est_pkg::EST_CORE_RUN) && best_ok
                     && (best_rank < run_rank) && take_ready;

    // Pending and active state per exception, walked as named states
    always_comb begin
        pend_d   = pend_q;
        act_d    = act_q;
        st_cur   = est_pkg::EST_INACTIVE;
        st_nxt   = est_pkg::EST_INACTIVE;
        ret_hit  = 1'b0;
        take_hit = 1'b0;
        for (int e = 0; e < `EST_NUM_EXC; e++) begin
            st_cur   = est_pkg::est_state_t'({act_q[e], pend_q[e]});
            ret_hit  = handler_return && (return_num == e[`EST_IDX_W-1:0]);
            take_hit = take_fire && (best_num == e[`EST_IDX_W-1:0]);
            // Set wins: a request in the entry cycle stays pending
            unique case (st_cur)
                est_pkg::EST_INACTIVE: begin
                    if (set_req[e]) begin
                        st_nxt = est_pkg::EST_PENDING;
                    end else begin
                        st_nxt = est_pkg::EST_INACTIVE;
                    end
                end
                est_pkg::EST_PENDING: begin
                    if (take_hit && set_req[e]) begin
                        st_nxt = est_pkg::EST_ACT_PEND;
                    end else if (take_hit) begin
                        st_nxt = est_pkg::EST_ACTIVE;
                    end else begin
                        st_nxt = est_pkg::EST_PENDING;
                    end
                end
                est_pkg::EST_ACTIVE: begin
                    if (ret_hit && set_req[e]) begin
                        st_nxt = est_pkg::EST_PENDING;
                    end else if (ret_hit) begin
                        st_nxt = est_pkg::EST_INACTIVE;
                    end else if (set_req[e]) begin
                        st_nxt = est_pkg::EST_ACT_PEND;
                    end else begin
                        st_nxt = est_pkg::EST_ACTIVE;
                    end
                end
                est_pkg::EST_ACT_PEND: begin
                    // Never picked here: its own rank bounds the running one
                    if (ret_hit) begin
                        st_nxt = est_pkg::EST_PENDING;
                    end else begin
                        st_nxt = est_pkg::EST_ACT_PEND;
                    end
                end
            endcase
            act_d[e]  = st_nxt[1];
            pend_d[e] = st_nxt[0];
        end
        pend_d[0] = 1'b0;
        pend_d[`EST_EXC_RESET] = 1'b0;
    end

    always_comb begin
        prio_d = prio_q;
        if (prio_cfg_we) begin
            prio_d = prio_cfg;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= '0;
            act_q  <= '0;
            prio_q <= {`EST_NUM_EXC{`EST_PRIO_RST_VAL}};
        end else begin
            pend_q <= pend_d;
            act_q  <= act_d;
            prio_q <= prio_d;
        end
    end

    // Core sequencing: reset, vector fetch, run
    always_comb begin
        core_d = core_q;
        take_d = '0;
        unique case (core_q)
            est_pkg::EST_CORE_RESET: begin
                core_d = est_pkg::EST_CORE_FETCH;
            end
            est_pkg::EST_CORE_FETCH: begin
                if (fetch_done) begin
                    core_d = est_pkg::EST_CORE_RUN;
                end
            end
            est_pkg::EST_CORE_RUN: begin
                if (take_fire) begin
                    take_d.valid = 1'b1;
                    take_d.num   = best_num;
                    take_d.vec_addr = 32'(best_num) * `EST_VEC_STEP;
                end
            end
            default: begin
                core_d = est_pkg::EST_CORE_RESET;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_q <= est_pkg::EST_CORE_RESET;
            take_q <= '0;
        end else begin
            core_q <= core_d;
            take_q <= take_d;
        end
    end

    // State export, two bits per exception: {active, pending}
    generate
        for (gi = 0; gi < `EST_NUM_EXC; gi++) begin : g_state
            assign exc_state[2*gi +: 2] = {act_q[gi], pend_q[gi]};
        end
    endgenerate

    assign take          = take_q;
    assign restart_addr  = `EST_VEC_RESET;
    assign restart_fetch = (core_q == est_pkg::EST_CORE_FETCH);
    assign core_run      = (core_q == est_pkg::EST_CORE_RUN);
    assign handler_mode  = |act_q;
    assign privileged    = 1'b1;

endmodule : est_tracker

// ### est_tracker_properties.sv
/*
 Port-level checker for est_tracker.
 Assumes core_clk and rst_n of the tracker; bound below to every instance.
*/
`timescale 1ns/100ps
module est_tracker_properties (
    // Clock and reset
    input wire logic               core_clk,
    input wire logic               rst_n,
    // Watched inputs
    input wire logic [15:0]        irq_req,
    input wire logic               nmi_pin,
    input wire logic               nmi_sw_set,
    input wire logic               take_ready,
    input wire logic               handler_return,
    input wire logic [4:0]         return_num,
    input wire logic               fetch_done,
    // Watched outputs
    input wire est_pkg::est_take_t take,
    input wire logic [63:0]        exc_state,
    input wire logic [31:0]        restart_addr,
    input wire logic               restart_fetch,
    input wire logic               core_run,
    input wire logic               handler_mode,
    input wire logic               privileged
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    vec_step_a: assert property (take.valid |-> take.vec_addr == {25'h0, take.num, 2'b00})
        else $error("vector not four bytes per number");
    entry_active_a: assert property (take.valid |-> exc_state[2*take.num+1])
        else $error("taken exception not active");
    irq_pend_a: assert property (irq_req[0] |=> exc_state[32])
        else $error("request did not pend");
    nmi_pend_a: assert property (nmi_pin || nmi_sw_set |=> exc_state[4])
        else $error("non-maskable request did not pend");
    nmi_first_a: assert property (exc_state[4] && !exc_state[5] && core_run && take_ready |=> take.valid && take.num == 5'h02)
        else $error("pending non-maskable not taken next");
    // A return in the deciding cycle may legally release the handler
    nmi_alone_a: assert property (take.valid && take.num != 5'h02 |-> !$past(exc_state[5] && !handler_return))
        else $error("non-maskable handler preempted");
    ret_clear_a: assert property (handler_return |=> !exc_state[2*$past(return_num)+1] || take.valid)
        else $error("return left exception active");
    reset_halt_a: assert property (disable iff (1'b0) !rst_n |-> !core_run && !restart_fetch && !take.valid && exc_state == 64'h0)
        else $error("activity during reset");
    boot_addr_a: assert property (restart_fetch |-> restart_addr == 32'h0000_0004 && !core_run)
        else $error("restart address wrong");
    fetch_run_a: assert property (restart_fetch && fetch_done |-> ##[1:2] core_run && !restart_fetch)
        else $error("fetch did not lead to run");
    thread_priv_a: assert property (privileged && handler_mode == |(exc_state & {32{2'b10}}))
        else $error("mode or privilege wrong");
endmodule : est_tracker_properties

bind est_tracker est_tracker_properties i_est_tracker_properties (.core_clk, .rst_n, .irq_req,
    .nmi_pin, .nmi_sw_set, .take_ready, .handler_return, .return_num, .fetch_done, .take,
    .exc_state, .restart_addr, .restart_fetch, .core_run, .handler_mode, .privileged);

// ### tb.sv
/*
 Self-checking bench for est_tracker.
 Assumes the checker is bound by its own file.
*/
`timescale 1ns/100ps
module tb;
    logic               core_clk = 1'b0;
    logic               rst_n = 1'b1;
    logic               go = 1'b0;
    logic [3:0]         sel = 4'h0;
    logic [14:0]        src = 15'h0000;
    logic               fetch_done = 1'b0;
    logic               take_ready = 1'b0;
    logic               handler_return = 1'b0;
    logic [4:0]         return_num = 5'h00;
    logic               bus_en = 1'b1;
    logic               trap_en = 1'b1;
    logic               usage_en = 1'b1;
    logic [15:0]        irq_en = 16'hffff;
    logic               prio_we = 1'b0;
    logic [255:0]       prio_cfg = 256'h0;
    logic [15:0]        irq_req;
    est_pkg::est_take_t take;
    logic [63:0]        exc_state;
    logic [31:0]        restart_addr;
    logic               restart_fetch;
    logic               core_run;
    logic               handler_mode;
    logic               privileged;
    int                 n_fail = 0;
    int                 checks_done = 0;
    logic [4:0]         exp_num [15] = '{5'h0f, 5'h0f, 5'h0e, 5'h02, 5'h02, 5'h0b, 5'h03,
                                         5'h03, 5'h05, 5'h06, 5'h06, 5'h06, 5'h06, 5'h06, 5'h06};

    est_irq_src i_est_irq_src (.core_clk, .go, .sel, .irq_req);
    est_tracker i_est_tracker (.core_clk, .rst_n, .irq_req, .irq_enable(irq_en),
        .nmi_pin(src[4]), .nmi_sw_set(src[3]), .deferred_service_request_set(src[2]),
        .tick_zero(src[1]), .tick_sw_set(src[0]), .bus_fault_enable(bus_en),
        .usage_fault_enable(usage_en), .unaligned_trap_enable(trap_en),
        .div_zero_trap_enable(trap_en), .events(est_pkg::est_events_t'(src[14:5])),
        .prio_cfg, .prio_cfg_we(prio_we), .take_ready, .handler_return, .return_num,
        .fetch_done, .take, .exc_state, .restart_addr, .restart_fetch, .core_run,
        .handler_mode, .privileged);

    initial forever #5 core_clk = ~core_clk;

    task automatic stop_test;
        if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_st(input int n, input logic [1:0] exp);
        @(negedge core_clk);
        chk(exc_state[2*n +: 2], exp);
    endtask : chk_st
    task automatic pulse(input logic [14:0] s);
        @(posedge core_clk);
        src <= s;
        @(posedge core_clk);
        src <= 15'h0000;
    endtask : pulse
    task automatic irq(input logic [3:0] n);
        @(posedge core_clk);
        go <= 1'b1;
        sel <= n;
        @(posedge core_clk);
        go <= 1'b0;
        @(posedge core_clk);
    endtask : irq
    task automatic serve(input logic [4:0] n);
        int i;
        @(posedge core_clk);
        take_ready <= 1'b1;
        i = 0;
        do begin
            @(negedge core_clk);
            i++;
        end while (take.valid !== 1'b1 && i < 20);
        chk({take.valid, take.num, take.vec_addr}, {1'b1, n, 25'h0, n, 2'b00});
        @(posedge core_clk);
        take_ready <= 1'b0;
    endtask : serve
    task automatic ret(input logic [4:0] n);
        @(posedge core_clk);
        handler_return <= 1'b1;
        return_num <= n;
        @(posedge core_clk);
        handler_return <= 1'b0;
    endtask : ret
    task automatic t_boot;
        @(posedge core_clk);
        rst_n <= 1'b0;
        @(negedge core_clk);
        chk({restart_fetch, core_run, take.valid, exc_state}, 67'h0);
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        @(negedge core_clk);
        chk({restart_fetch, core_run, handler_mode, privileged, exc_state}, {4'b1001, 64'h0});
        chk(restart_addr, 32'h0000_0004);
        @(posedge core_clk);
        fetch_done <= 1'b1;
        @(posedge core_clk);
        fetch_done <= 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk(core_run, 1'b1);
    endtask : t_boot
    task automatic t_irq;
        irq(4'h0);
        chk_st(16, 2'b01);
        serve(5'h10);
        chk_st(16, 2'b10);
        irq(4'h0);
        chk_st(16, 2'b11);
        ret(5'h10);
        chk_st(16, 2'b01);
        t_boot();
    endtask : t_irq
    task automatic t_nest;
        irq(4'h0);
        serve(5'h10);
        irq(4'h1);
        take_ready <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk_st(17, 2'b01);
        pulse(15'h0010);
        serve(5'h02);
        chk_st(16, 2'b10);
        @(posedge core_clk);
        take_ready <= 1'b1;
        pulse(15'h0080);
        repeat (4) @(posedge core_clk);
        chk_st(3, 2'b01);
        ret(5'h02);
        serve(5'h03);
        ret(5'h03);
        ret(5'h10);
        serve(5'h11);
        ret(5'h11);
        @(negedge core_clk);
        chk(exc_state, 64'h0);
    endtask : t_nest
    task automatic t_prio;
        logic [4:0] order [4] = '{5'h03, 5'h0f, 5'h10, 5'h0e};
        @(posedge core_clk);
        prio_cfg <= 256'h20_1030 << 112;
        prio_we <= 1'b1;
        @(posedge core_clk);
        prio_we <= 1'b0;
        irq(4'h0);
        pulse(15'h0086);
        foreach (order[i]) begin
            serve(order[i]);
            ret(order[i]);
        end
    endtask : t_prio
    task automatic t_faults;
        for (int i = 0; i < 15; i++) begin
            pulse(15'h0001 << i);
            serve(exp_num[i]);
            ret(exp_num[i]);
        end
        @(posedge core_clk);
        trap_en <= 1'b0;
        pulse(15'h0600);
        chk_st(6, 2'b00);
        @(posedge core_clk);
        bus_en <= 1'b0;
        pulse(15'h0100);
        serve(5'h03);
        ret(5'h03);
        @(posedge core_clk);
        usage_en <= 1'b0;
        pulse(15'h4000);
        serve(5'h03);
        ret(5'h03);
        chk_st(6, 2'b00);
        @(posedge core_clk);
        irq_en <= 16'hfffd;
        take_ready <= 1'b1;
        irq(4'h1);
        repeat (4) @(posedge core_clk);
        chk_st(17, 2'b01);
        @(posedge core_clk);
        irq_en <= 16'hffff;
        serve(5'h11);
        ret(5'h11);
    endtask : t_faults

    initial begin
        // Reset from time zero so no edge ever samples unknown state
        rst_n <= 1'b0;
        t_boot();
        t_irq();
        t_nest();
        t_prio();
        t_faults();
        stop_test();
    end
    // Whole sequence needs well under 2000 cycles
    initial begin
        #50us;
        n_fail++;
        stop_test();
    end
endmodule : tb
